// ### core/lcm_cell.sv
/*
 * Programmable logic cell: table, one register, four modes, six
 * asynchronous control schemes, chip-wide reset and tri-state
 * emulation, configured over an Avalon-MM slave.
 * Assumes one clock mclk; the cell clock arrives as a one-cycle
 * enable cell_tick; all pins are synchronous to mclk.
 */
// Functional notes
// [RULE_01] Four modes: normal, arithmetic, up/down, clearable
// [RULE_02] Register has synchronous enable, input one optional
// [RULE_03] Normal: four-input table, carry or input three
// [RULE_04] Cascade combine; register or table drives outputs
// [RULE_05] Packing: input four loads register, outputs independent
// [RULE_06] Arithmetic: sum table and carry table
// [RULE_07] Arithmetic still allows cascade chain
// [RULE_08] Up/down: enables, direction, load multiplexer
// [RULE_09] Counters loadable asynchronously via clear/preset
// [RULE_10] Clearable: cascade-in is synchronous clear, ANDed
// [RULE_11] Tri-state emulation: contention low, float high
// [RULE_12] Clear and preset active low, unused high
// [RULE_13] Control A copies input three immediately
// [RULE_14] Six asynchronous control schemes
// [RULE_15] Clear scheme: either control line clears
// [RULE_16] Chip-wide reset overrides everything when enabled
// [RULE_17] Inverted registers show preset under chip reset
// [RULE_18] Preset by loading one or inverted clear
// [RULE_19] Clear-preset: A presets, B clears
// [RULE_20] Load-clear: A loads, B clears
// [RULE_21] Load-preset: stored inverted, B presets, A loads
// [RULE_22] Counters update only with both enables
`include "lcm_regs.svh"

module lcm_cell (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        cell_tick,
	input  wire logic        cell_input_one,
	input  wire logic        cell_input_two,
	input  wire logic        cell_input_three,
	input  wire logic        cell_input_four,
	input  wire logic        carry_in,
	input  wire logic        cascade_in,
	input  wire logic        cluster_control_a,
	input  wire logic        cluster_control_b,
	input  wire logic        chip_reset_n,
	output logic             local_out,
	output logic             global_out,
	output logic             carry_out,
	output logic             cascade_out,
	output logic             tri_bus_out
);

	// ==========================================================
	// Declarations
	logic [`LCM_CTRL_W-1:0]  ctrl_reg;
	logic [15:0]             mask_reg;
	logic                    ack_reg;
	logic [31:0]             readdata_reg;
	logic [31:0]             ctrl_merged;
	logic [31:0]             mask_merged;
	logic                    stored_reg;
	logic [31:0]             stat_word;
	lcm_pkg::lcm_mode_type   mode;
	lcm_pkg::lcm_scheme_type scheme;
	logic                    pre_n;
	logic                    clr_n;
	logic                    inv;
	logic                    chip_rst;
	logic                    forced;
	logic                    store_eff;
	logic                    q;
	logic [3:0]              lut_idx;
	logic                    lut_f4;
	logic                    lut_lo;
	logic                    lut_hi;
	logic                    comb_out;
	logic                    carry_int;
	logic                    casc_int;
	logic                    d_val;
	logic                    upd;
	logic                    ce;
	logic                    bus_val;
	logic                    wr_go;
	logic                    rd_start;

	// Load of a value through both active-low controls: {pre_n, clr_n}
	function automatic logic [1:0] load_ctl(input logic ctl,
		input logic d);
		load_ctl = {~(ctl & d), ~(ctl & ~d)};
	endfunction

	// Byte-enable merge of one 32-bit write onto a register value
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		be_merge = r;
	endfunction

	// ==========================================================
	// Avalon-MM slave
	// One wait cycle on every access keeps read data registered.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr_go           = avs_write & ack_reg;
	assign rd_start        = avs_read & ~ack_reg;
	assign avs_readdata    = readdata_reg;

	// Merged words are cut to register width at the store
	assign ctrl_merged = be_merge({12'h000, ctrl_reg}, avs_writedata,
		avs_byteenable);
	assign mask_merged = be_merge({16'h0000, mask_reg}, avs_writedata,
		avs_byteenable);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read | avs_write) & ~ack_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_reg <= `LCM_CTRL_RST;
		end else if (wr_go && avs_address == `LCM_CTRL_OFS) begin
			ctrl_reg <= ctrl_merged[`LCM_CTRL_W-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mask_reg <= `LCM_MASK_RST;
		end else if (wr_go && avs_address == `LCM_MASK_OFS) begin
			mask_reg <= mask_merged[15:0];
		end
	end

	always_comb begin
		stat_word                 = 32'h00000000;
		stat_word[`LCM_S_Q]       = q;
		stat_word[`LCM_S_LOCAL]   = local_out;
		stat_word[`LCM_S_GLOBAL]  = global_out;
		stat_word[`LCM_S_CARRY]   = carry_out;
		stat_word[`LCM_S_CASCADE] = cascade_out;
		stat_word[`LCM_S_TRI]     = tri_bus_out;
		stat_word[`LCM_S_STORED]  = stored_reg;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			readdata_reg <= 32'h00000000;
		end else if (rd_start) begin
			case (avs_address)
				`LCM_CTRL_OFS: readdata_reg <= {12'h000, ctrl_reg};
				`LCM_MASK_OFS: readdata_reg <= {16'h0000, mask_reg};
				`LCM_STAT_OFS: readdata_reg <= stat_word;
				default:       readdata_reg <= 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// Configuration decode
	assign mode   = lcm_pkg::lcm_mode_type'(
		ctrl_reg[`LCM_F_MODE_HI:`LCM_F_MODE_LO]);
	assign scheme = lcm_pkg::lcm_scheme_type'(
		ctrl_reg[`LCM_F_SCH_HI:`LCM_F_SCH_LO]);

	// ==========================================================
	// Asynchronous control schemes
	// Internal controls stay high when a scheme leaves them unused.
	always_comb begin
		pre_n = 1'b1;                                  // [RULE_12]
		clr_n = 1'b1;                                  // [RULE_12]
		inv   = 1'b0;
		case (scheme)                                  // [RULE_14]
			lcm_pkg::LCM_SCH_CLEAR: begin
				clr_n = ~(cluster_control_a | cluster_control_b); // [RULE_15]
			end
			lcm_pkg::LCM_SCH_PRESET: begin
				if (ctrl_reg[`LCM_F_PRE_INV]) begin
					inv   = 1'b1;                      // [RULE_18]
					clr_n = ~cluster_control_a;        // [RULE_18]
				end else begin
					{pre_n, clr_n} = load_ctl(cluster_control_a, 1'b1); // [RULE_18]
				end
			end
			lcm_pkg::LCM_SCH_CLR_PRE: begin
				{pre_n, clr_n} = load_ctl(cluster_control_a, 1'b1); // [RULE_19]
				clr_n = clr_n & ~cluster_control_b;    // [RULE_19]
			end
			lcm_pkg::LCM_SCH_LOAD_CLR: begin
				{pre_n, clr_n} = load_ctl(cluster_control_a,
					cell_input_three);                 // [RULE_20]
				clr_n = clr_n & ~cluster_control_b;    // [RULE_20]
			end
			lcm_pkg::LCM_SCH_LOAD_PRE: begin
				inv = 1'b1;                            // [RULE_21]
				{pre_n, clr_n} = load_ctl(cluster_control_a,
					~cell_input_three);                // [RULE_21]
				clr_n = clr_n & ~cluster_control_b;    // [RULE_21]
			end
			lcm_pkg::LCM_SCH_LOAD: begin
				{pre_n, clr_n} = load_ctl(cluster_control_a,
					cell_input_three);                 // [RULE_13]
			end
			default: begin
				pre_n = 1'b1;
				clr_n = 1'b1;
			end
		endcase
	end

	// Forced value shows at once; the register catches it at the edge.
	// Clear wins over preset when both act.
	assign chip_rst = ctrl_reg[`LCM_F_CHIPRST_EN] & ~chip_reset_n;

	always_comb begin
		forced    = 1'b1;
		store_eff = 1'b0;
		if (chip_rst) begin
			store_eff = 1'b0;                          // [RULE_16]
		end else if (!clr_n) begin
			store_eff = 1'b0;                          // [RULE_09]
		end else if (!pre_n) begin
			store_eff = 1'b1;                          // [RULE_09]
		end else begin
			forced    = 1'b0;
			store_eff = stored_reg;
		end
	end

	// Inverted storage reads as one after chip reset
	assign q = store_eff ^ inv;                        // [RULE_17]

	// ==========================================================
	// Function generator
	lcm_lut u_lut (
		.mask  (mask_reg),
		.idx   (lut_idx),
		.f4    (lut_f4),
		.f3_lo (lut_lo),
		.f3_hi (lut_hi)
	);

	// ==========================================================
	// Mode datapath
	assign ce = ctrl_reg[`LCM_F_CE_IN1] ? cell_input_one : 1'b1; // [RULE_02]

	always_comb begin
		lut_idx   = 4'h0;
		comb_out  = 1'b0;
		carry_int = 1'b0;
		casc_int  = 1'b0;
		d_val     = 1'b0;
		upd       = 1'b0;
		case (mode)                                    // [RULE_01]
			lcm_pkg::LCM_NORMAL: begin
				lut_idx = {cell_input_four,
					ctrl_reg[`LCM_F_LUT_CARRY] ? carry_in
						: cell_input_three,
					cell_input_two, cell_input_one};   // [RULE_03]
				comb_out = lut_f4;
				casc_int = ctrl_reg[`LCM_F_CASC_EN]
					? (lut_f4 & cascade_in) : lut_f4;  // [RULE_04]
				d_val = ctrl_reg[`LCM_F_PACK]
					? cell_input_four : casc_int;      // [RULE_05]
				upd = ce;                              // [RULE_02]
			end
			lcm_pkg::LCM_ARITH: begin
				lut_idx   = {1'b0, carry_in, cell_input_two,
					cell_input_one};                   // [RULE_06]
				comb_out  = lut_lo;                    // [RULE_06]
				carry_int = lut_hi;                    // [RULE_06]
				casc_int  = ctrl_reg[`LCM_F_CASC_EN]
					? (lut_lo & cascade_in) : lut_lo;  // [RULE_07]
				d_val = lut_lo;
				upd   = ce;                            // [RULE_02]
			end
			lcm_pkg::LCM_UPDOWN: begin
				// Input two enables counting, input four selects load
				lut_idx   = {1'b0, carry_in, q, cascade_in}; // [RULE_08]
				comb_out  = lut_lo;
				carry_int = lut_hi;                    // [RULE_08]
				casc_int  = lut_lo;
				d_val = cell_input_four
					? cell_input_three : lut_lo;       // [RULE_08]
				upd = ce & cell_input_two;             // [RULE_22]
			end
			lcm_pkg::LCM_CLRCNT: begin
				// Direction fixed; cascade-in low clears synchronously
				lut_idx   = {1'b0, carry_in, q, 1'b1};
				comb_out  = lut_lo;
				carry_int = lut_hi;
				casc_int  = lut_lo;
				d_val = (cell_input_four ? cell_input_three : lut_lo)
					& cascade_in;                      // [RULE_10]
				upd = ce & cell_input_two;             // [RULE_22]
			end
			default: begin
				upd = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Cell register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			stored_reg <= 1'b0;
		end else if (forced) begin
			stored_reg <= store_eff;                   // [RULE_16]
		end else if (cell_tick && upd) begin
			stored_reg <= d_val ^ inv;                 // [RULE_21]
		end
	end

	// ==========================================================
	// Outputs
	assign local_out   = ctrl_reg[`LCM_F_LOCAL_REG] ? q : comb_out;  // [RULE_05]
	assign global_out  = ctrl_reg[`LCM_F_GLOBAL_REG] ? q : comb_out; // [RULE_05]
	assign carry_out   = carry_int;
	assign cascade_out = casc_int;

	lcm_tri_emul u_tri (
		.drv ({casc_int, carry_int, comb_out, q}),
		.oe  (ctrl_reg[`LCM_F_OE_HI:`LCM_F_OE_LO]),
		.bus (bus_val)                                 // [RULE_11]
	);

	assign tri_bus_out = bus_val;

endmodule

// ### core/lcm_lut.sv
/*
 * Function generator of the cell: one four-input table, also read as
 * two three-input tables (low and high halves). Purely combinational.
 */
module lcm_lut (
	input  wire logic [15:0] mask,
	input  wire logic [3:0]  idx,
	output logic             f4,
	output logic             f3_lo,
	output logic             f3_hi
);

	// ==========================================================
	// Table lookup
	assign f4    = mask[idx];
	assign f3_lo = mask[{1'b0, idx[2:0]}];
	assign f3_hi = mask[{1'b1, idx[2:0]}];

endmodule

// ### core/lcm_pkg.sv
/*
 * Types of the logic cell model: operating modes and asynchronous
 * control schemes. Assumes nothing of its surroundings.
 */
package lcm_pkg;

	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		LCM_NORMAL,
		LCM_ARITH,
		LCM_UPDOWN,
		LCM_CLRCNT
	} lcm_mode_type;

	// ==========================================================
	// Asynchronous clear, preset and load schemes
	typedef enum logic [2:0] {
		LCM_SCH_CLEAR,
		LCM_SCH_PRESET,
		LCM_SCH_CLR_PRE,
		LCM_SCH_LOAD_CLR,
		LCM_SCH_LOAD_PRE,
		LCM_SCH_LOAD
	} lcm_scheme_type;

endpackage

// ### core/lcm_regs.svh
/*
 * Register offsets, field positions and reset values of the logic cell
 * model. Assumes a byte-addressed Avalon-MM slave with 32-bit words.
 */
`ifndef LCM_REGS_SVH
`define LCM_REGS_SVH

// ==========================================================
// Offsets
`define LCM_CTRL_OFS      4'h0
`define LCM_MASK_OFS      4'h4
`define LCM_STAT_OFS      4'h8

// ==========================================================
// Control fields
`define LCM_F_MODE_LO     0
`define LCM_F_MODE_HI     1
`define LCM_F_SCH_LO      2
`define LCM_F_SCH_HI      4
`define LCM_F_CE_IN1      5
`define LCM_F_LUT_CARRY   6
`define LCM_F_PACK        7
`define LCM_F_LOCAL_REG   8
`define LCM_F_GLOBAL_REG  9
`define LCM_F_CASC_EN     10
`define LCM_F_CHIPRST_EN  11
`define LCM_F_PRE_INV     12
`define LCM_F_OE_LO       16
`define LCM_F_OE_HI       19
`define LCM_CTRL_W        20

// ==========================================================
// Status fields
`define LCM_S_Q           0
`define LCM_S_LOCAL       1
`define LCM_S_GLOBAL      2
`define LCM_S_CARRY       3
`define LCM_S_CASCADE     4
`define LCM_S_TRI         5
`define LCM_S_STORED      6

// ==========================================================
// Reset values
`define LCM_CTRL_RST      20'h00000
`define LCM_MASK_RST      16'h0000

`endif

// ### core/lcm_tri_emul.sv
/*
 * Emulated internal tri-state bus built from a multiplexer.
 * Assumes four drivers, each with its own enable.
 */
module lcm_tri_emul (
	input  wire logic [3:0] drv,
	input  wire logic [3:0] oe,
	output logic            bus
);

	// ==========================================================
	// Resolution
	always_comb begin
		case (oe)
			4'h0:    bus = 1'b1;    // Floating bus reads high
			4'h1:    bus = drv[0];
			4'h2:    bus = drv[1];
			4'h4:    bus = drv[2];
			4'h8:    bus = drv[3];
			default: bus = 1'b0;    // Contention resolves low
		endcase
	end

endmodule

// ### dv/lcm_cell_properties.sv
/*
 * Port checker of the logic cell: bus wait, tri emulation, schemes.
 * Assumes binding to lcm_cell; control is snooped from bus writes.
 */
`include "lcm_regs.svh"

module lcm_cell_checker (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic        cell_tick,
	input wire logic        cell_input_two,
	input wire logic        cell_input_three,
	input wire logic        cluster_control_a,
	input wire logic        cluster_control_b,
	input wire logic        chip_reset_n,
	input wire logic        local_out,
	input wire logic        tri_bus_out
);
	// ==========
	// Shadow control
	logic [23:0] ctrl_reg;
	logic        rst_act;
	logic [2:0]  sch;
	logic        rq;
	logic        ca;
	logic        cb_in;
	assign rst_act = ctrl_reg[11] && !chip_reset_n;
	assign sch     = ctrl_reg[4:2];
	assign rq      = ctrl_reg[8];
	assign ca      = cluster_control_a;
	assign cb_in   = cluster_control_b;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_reg <= 24'h000000;
		end else if (avs_write && !avs_waitrequest
		    && avs_address == `LCM_CTRL_OFS) begin
			for (int i = 0; i < 3; i++) begin
				if (avs_byteenable[i]) begin
					ctrl_reg[i*8 +: 8] <= avs_writedata[i*8 +: 8];
				end
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// ==========
	// Properties
	sequence s_quiet;
		ctrl_reg[1] && rq && !rst_act && !ca && !cb_in;
	endsequence
	sequence s_no_count;
		s_quiet ##0 !(cell_tick && cell_input_two);
	endsequence
	property p_wait_one;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	property p_tri_float;
		ctrl_reg[19:16] == 4'h0 |-> tri_bus_out;
	endproperty
	property p_tri_fight;
		$countones(ctrl_reg[19:16]) > 1 |-> !tri_bus_out;
	endproperty
	property p_clr_any;
		sch == 3'h0 && rq && (ca || cb_in) |-> !local_out;
	endproperty
	property p_cp_set;
		sch == 3'h2 && rq && !rst_act && ca && !cb_in |-> local_out;
	endproperty
	property p_cp_clr;
		sch == 3'h2 && rq && cb_in |-> !local_out;
	endproperty
	property p_load_now;
		sch == 3'h5 && rq && !rst_act && ca
		    |-> local_out == cell_input_three;
	endproperty
	property p_chip_clr;
		rst_act && rq && sch == 3'h0 |-> !local_out;
	endproperty
	property p_chip_inv;
		rst_act && rq && sch == 3'h4 |-> local_out;
	endproperty
	property p_cnt_hold;
		s_no_count ##1 s_quiet |-> $stable(local_out);
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("no answer");
	a_tri_float: assert property (p_tri_float) else $error("float");
	a_tri_fight: assert property (p_tri_fight) else $error("fight");
	a_clr_any: assert property (p_clr_any) else $error("clr");
	a_cp_set: assert property (p_cp_set) else $error("pre");
	a_cp_clr: assert property (p_cp_clr) else $error("cp clr");
	a_load_now: assert property (p_load_now) else $error("load");
	a_chip_clr: assert property (p_chip_clr) else $error("chip");
	a_chip_inv: assert property (p_chip_inv) else $error("inv");
	a_cnt_hold: assert property (p_cnt_hold) else $error("hold");
endmodule

bind lcm_cell lcm_cell_checker i_lcm_cell_checker (.mclk, .resetn,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .cell_tick, .cell_input_two, .cell_input_three,
    .cluster_control_a, .cluster_control_b, .chip_reset_n, .local_out,
    .tri_bus_out);

// ### dv/lcm_cell_tb_top.sv
/*
 * Self-checking bench of the logic cell: schemes, counter, table.
 * Assumes lcm_cell, lcm_prev_cell and the bound checker compiled.
 */
`include "lcm_regs.svh"

module lcm_cell_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Signals
	logic        mclk = 1'h0, resetn = 1'h0;
	logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
	logic        avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic        cell_tick = 1'h0, cell_input_one = 1'h0;
	logic        cell_input_two = 1'h0, cell_input_three = 1'h0;
	logic        cell_input_four = 1'h0, carry_in, cascade_in;
	logic        carry_d = 1'h0, casc_d = 1'h1, chip_reset_n = 1'h1;
	logic        cluster_control_a = 1'h0, cluster_control_b = 1'h0;
	logic        local_out, global_out, carry_out, cascade_out;
	logic        tri_bus_out;
	int          err_total = 0;
	int          n_tests = 0;

	always #4 mclk = ~mclk;

	lcm_prev_cell i_lcm_prev_cell (.mclk, .resetn, .carry_d, .casc_d,
	    .carry_in, .cascade_in);
	lcm_cell i_lcm_cell (.mclk, .resetn, .avs_address, .avs_read,
	    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	    .avs_waitrequest, .cell_tick, .cell_input_one, .cell_input_two,
	    .cell_input_three, .cell_input_four, .carry_in, .cascade_in,
	    .cluster_control_a, .cluster_control_b, .chip_reset_n,
	    .local_out, .global_out, .carry_out, .cascade_out, .tri_bus_out);

	// ==========
	// Tasks
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] adr,
	    input logic [31:0] wd, output logic [31:0] rd);
		int k;
		@(posedge mclk);
		avs_address <= adr;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		for (k = 0; k < 16; k++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'h0) break;
		end
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (k == 16) begin
			err_total++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [3:0] adr, input logic [31:0] d);
		logic [31:0] v;
		bus(1'h1, adr, d, v);
	endtask
	task automatic rchk(input logic [3:0] adr, input logic [31:0] e);
		logic [31:0] v;
		bus(1'h0, adr, 32'h0, v);
		chk(v, e);
	endtask
	// Bits: control a, control b, input three, chip reset
	task automatic drv(input logic [3:0] v);
		@(posedge mclk);
		{cluster_control_a, cluster_control_b, cell_input_three,
		    chip_reset_n} <= v;
		@(negedge mclk);
	endtask
	// Ends with a release so the forced value gets stored
	task automatic sc(input logic [31:0] c, input logic [3:0] v,
	    input logic e);
		wr(`LCM_CTRL_OFS, c);
		drv(v);
		chk(local_out, e);
		drv(4'h1);
	endtask
	// Bits: inputs one, two, three, four; one tick
	task automatic tick(input logic [3:0] v);
		@(posedge mclk);
		{cell_input_one, cell_input_two, cell_input_three,
		    cell_input_four} <= v;
		cell_tick <= 1'h1;
		@(posedge mclk);
		cell_tick <= 1'h0;
		@(negedge mclk);
	endtask

	// ==========
	// Sequence
	initial begin
		repeat (2) @(posedge mclk);
		resetn <= 1'h1;
		rchk(`LCM_CTRL_OFS, 32'h0);
		rchk(`LCM_MASK_OFS, 32'h0);
		rchk(4'hC, 32'h0);
		wr(`LCM_CTRL_OFS, 32'hFFFFFFFF);
		rchk(`LCM_CTRL_OFS, 32'h000FFFFF);
		@(negedge mclk);
		chk(tri_bus_out, 1'h0);
		sc(32'h914, 4'hB, 1'h1);
		sc(32'h914, 4'h9, 1'h0);
		sc(32'h914, 4'hB, 1'h1);
		sc(32'h900, 4'h5, 1'h0);
		sc(32'h914, 4'hB, 1'h1);
		sc(32'h900, 4'h9, 1'h0);
		sc(32'h908, 4'h9, 1'h1);
		sc(32'h908, 4'hD, 1'h0);
		sc(32'h90C, 4'hB, 1'h1);
		sc(32'h90C, 4'h5, 1'h0);
		sc(32'h910, 4'h5, 1'h1);
		sc(32'h910, 4'h0, 1'h1);
		sc(32'h904, 4'h9, 1'h1);
		sc(32'h1904, 4'h9, 1'h1);
		sc(32'h90A, 4'h9, 1'h1);
		sc(32'h918, 4'hD, 1'h1);
		sc(32'h900, 4'h0, 1'h0);
		sc(32'h914, 4'hA, 1'h0);
		chk(tri_bus_out, 1'h1);
		// Count table toggles the register
		wr(`LCM_MASK_OFS, 32'h0033);
		wr(`LCM_CTRL_OFS, 32'h13A);
		tick(4'hF);
		chk(local_out, 1'h1);
		tick(4'hC);
		chk(local_out, 1'h0);
		tick(4'h8);
		chk(local_out, 1'h0);
		tick(4'h4);
		chk(local_out, 1'h0);
		tick(4'hC);
		chk(local_out, 1'h1);
		wr(`LCM_CTRL_OFS, 32'h13B);
		tick(4'hC);
		chk(local_out, 1'h0);
		@(posedge mclk);
		casc_d <= 1'h0;
		tick(4'hC);
		chk(local_out, 1'h0);
		@(posedge mclk);
		casc_d <= 1'h1;
		wr(`LCM_MASK_OFS, 32'h8000);
		wr(`LCM_CTRL_OFS, 32'h400);
		tick(4'hF);
		chk({local_out, global_out, cascade_out}, 3'h7);
		@(posedge mclk);
		casc_d <= 1'h0;
		repeat (2) @(negedge mclk);
		chk(cascade_out, 1'h0);
		wr(`LCM_CTRL_OFS, 32'h440);
		@(posedge mclk);
		casc_d <= 1'h1;
		carry_d <= 1'h1;
		tick(4'hD);
		chk(local_out, 1'h1);
		wr(`LCM_CTRL_OFS, 32'h680);
		tick(4'hD);
		chk({local_out, global_out}, 2'h1);
		wr(`LCM_MASK_OFS, 32'hE896);
		wr(`LCM_CTRL_OFS, 32'h401);
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			carry_d <= i[2];
			tick({i[0], i[1], 2'h0});
			chk(local_out, ^i[2:0]);
			chk(carry_out, i[2] & i[1] | i[2] & i[0] | i[1] & i[0]);
			chk(cascade_out, ^i[2:0]);
		end
		rchk(`LCM_STAT_OFS, 32'h7F);
		finish_test();
	end
endmodule

// ### dv/lcm_prev_cell.sv
/*
 * Previous cell of the chain: hands on carry and cascade.
 * Assumes the bench sets carry_d and casc_d at mclk edges.
 */
module lcm_prev_cell (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic carry_d,
	input  wire logic casc_d,
	output logic      carry_in,
	output logic      cascade_in
);
	// ==========
	// Chain outputs
	// Registered, so they move only at edges; cascade idles high
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			carry_in   <= 1'h0;
			cascade_in <= 1'h1;
		end else begin
			carry_in   <= carry_d;
			cascade_in <= casc_d;
		end
	end
endmodule
